// ### lbhp_cfg.svh
// constants of the local bus host port
`ifndef LBHP_CFG_SVH
`define LBHP_CFG_SVH
`define LBHP_ADDR_W 20
`define LBHP_DATA_W 16
`define LBHP_RST_FILT_NS 100
`define LBHP_CLK_NS 8
`define LBHP_RST_FILT_CYC ((`LBHP_RST_FILT_NS + `LBHP_CLK_NS - 1) / `LBHP_CLK_NS)
`define LBHP_IO_SIZE_LOG2 4
`define LBHP_WAIT_CYC 2
`endif

// ### lbhp_pkg.sv
// types of the local bus host port
package lbhp_pkg;
    typedef enum logic [1:0] {
        LBHP_IDLE = 2'b00,
        LBHP_WAIT = 2'b01,
        LBHP_DONE = 2'b10
    } lbhp_st_t;

    typedef struct packed {
        logic [19:0] addr;
        logic ube_n;
    } lbhp_addr_t;

    typedef struct packed {
        logic [2:0] rd_s;
        logic [2:0] wr_s;
        logic [2:0] mr_s;
        logic [2:0] ale_s;
        logic [2:0] aq_s;
        logic [2:0] rst_s;
        logic [2:0] strap_s;
        lbhp_addr_t lat;
        logic [7:0] rst_cnt;
        logic rst_int;
        logic local_mode;
        lbhp_st_t st;
        logic [1:0] wcnt;
        logic rom_cs_n;
        logic rom_oe_n;
        logic wide_n;
        logic rdy_oe_n;
        logic [15:0] dout;
        logic d_oe_n;
        logic wr_pulse;
        logic rd_pulse;
        logic [15:0] wdata;
        logic [3:0] reg_idx;
        logic [1:0] lanes;
        logic [3:0] irq_o;
        logic [3:0] irq_oe_n;
    } lbhp_state_t;
endpackage : lbhp_pkg

// ### lbhp_top.sv
// local bus host port: decode, data bus, ready, rom select, reset filter, interrupt steer
`timescale 1ns/1ns
`default_nettype none
`include "lbhp_cfg.svh"
module lbhp_top #(
    parameter int ADDR_W = `LBHP_ADDR_W,
    parameter int WAIT_CYC = `LBHP_WAIT_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // host address and control pins
    input wire logic [19:0] addr_in,
    input wire logic address_qualifier,
    input wire logic upper_byte_enable_low,
    input wire logic address_latch_strobe,
    input wire logic io_read_strobe_low,
    input wire logic io_write_strobe_low,
    input wire logic memory_read_strobe_low,
    input wire logic reset_pin,
    input wire logic use_latch,
    // data bus pins
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe_n,
    // ready open drain, wide cycle indicator driven at both levels
    output logic cycle_extend_ready_oe_n,
    output logic wide_cycle_indicator_low,
    // boot rom strap and select
    input wire logic boot_rom_select_strap_in,
    output logic boot_rom_select_strap_out,
    output logic boot_rom_select_strap_oe_n,
    // configuration from the core
    input wire logic [15:0] io_base,
    input wire logic [19:0] rom_base,
    input wire logic [19:0] rom_mask,
    input wire logic wide_mode,
    input wire logic [1:0] interrupt_line_select,
    input wire logic irq_pending,
    input wire logic extend_en,
    // register side toward the core
    input wire logic [15:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [3:0] reg_idx,
    output logic [15:0] reg_wdata,
    output logic [1:0] reg_lanes,
    output logic chip_reset,
    output logic local_bus_mode,
    // interrupt lines
    output logic [3:0] interrupt_line,
    output logic [3:0] interrupt_line_oe_n
);
    lbhp_pkg::lbhp_state_t s_ff, nxt_s;
    localparam int FILT = `LBHP_RST_FILT_CYC;

    logic rd_l, wr_l, mr_l, ale_q, aq_l;
    logic [19:0] a_use;
    logic ube_use, io_hit, rom_hit, rd_act, wr_act;

    // ****************************************
    // synchronised levels: second and third stage agree
    // ****************************************
    function automatic logic sync_lvl(input logic [2:0] sh, input logic prev);
        sync_lvl = (sh[1] == sh[2]) ? sh[2] : prev;
    endfunction : sync_lvl

    always_comb begin
        rd_l = sync_lvl(s_ff.rd_s, 1'b1);
        wr_l = sync_lvl(s_ff.wr_s, 1'b1);
        mr_l = sync_lvl(s_ff.mr_s, 1'b1);
        aq_l = sync_lvl(s_ff.aq_s, 1'b1);
        ale_q = s_ff.ale_s[2];
        a_use = use_latch ? s_ff.lat.addr : addr_in;
        ube_use = use_latch ? s_ff.lat.ube_n : upper_byte_enable_low;
        io_hit = !aq_l && (a_use[19:16] == 4'h0) &&
            (a_use[15:`LBHP_IO_SIZE_LOG2] == io_base[15:`LBHP_IO_SIZE_LOG2]);
        rom_hit = ((a_use & rom_mask) == (rom_base & rom_mask));
        rd_act = io_hit && !rd_l;
        wr_act = io_hit && !wr_l;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        nxt_s = s_ff;
        nxt_s.rd_s = {s_ff.rd_s[1:0], io_read_strobe_low};
        nxt_s.wr_s = {s_ff.wr_s[1:0], io_write_strobe_low};
        nxt_s.mr_s = {s_ff.mr_s[1:0], memory_read_strobe_low};
        nxt_s.ale_s = {s_ff.ale_s[1:0], address_latch_strobe};
        nxt_s.aq_s = {s_ff.aq_s[1:0], address_qualifier};
        nxt_s.rst_s = {s_ff.rst_s[1:0], reset_pin};
        nxt_s.strap_s = {s_ff.strap_s[1:0], boot_rom_select_strap_in};
        nxt_s.wr_pulse = 1'b0;
        nxt_s.rd_pulse = 1'b0;

        if (s_ff.rst_s[1] && s_ff.rst_s[2]) begin
            if (s_ff.rst_cnt < 8'(FILT))
                nxt_s.rst_cnt = s_ff.rst_cnt + 8'h01;
            else
                nxt_s.rst_int = 1'b1;
        end else if (!s_ff.rst_s[1] && !s_ff.rst_s[2]) begin
            nxt_s.rst_cnt = 8'h00;
            nxt_s.rst_int = 1'b0;
            if (s_ff.rst_int)
                nxt_s.local_mode = s_ff.strap_s[2];
        end

        // latch on falling edge of strobe
        if (s_ff.ale_s[2] && !s_ff.ale_s[1]) begin
            nxt_s.lat.addr = addr_in;
            nxt_s.lat.ube_n = upper_byte_enable_low;
        end

        nxt_s.rom_cs_n = !(s_ff.local_mode && !mr_l && rom_hit && !aq_l);
        nxt_s.rom_oe_n = !s_ff.local_mode;

        nxt_s.wide_n = !(wide_mode && !aq_l &&
            (a_use[15:4] == io_base[15:4]));

        case (s_ff.st)
            lbhp_pkg::LBHP_IDLE: begin
                nxt_s.rdy_oe_n = 1'b1;
                if (rd_act || wr_act) begin
                    nxt_s.reg_idx = a_use[3:0];
                    // upper lane only when enable low
                    nxt_s.lanes = {!ube_use, !a_use[0]};
                    nxt_s.wdata = data_in;
                    if (extend_en) begin
                        nxt_s.rdy_oe_n = 1'b0;
                        nxt_s.wcnt = 2'(WAIT_CYC);
                        nxt_s.st = lbhp_pkg::LBHP_WAIT;
                    end else begin
                        nxt_s.st = lbhp_pkg::LBHP_DONE;
                        nxt_s.wr_pulse = wr_act;
                        nxt_s.rd_pulse = rd_act;
                    end
                end
            end
            lbhp_pkg::LBHP_WAIT: begin
                nxt_s.wcnt = s_ff.wcnt - 2'h1;
                if (s_ff.wcnt == 2'h1) begin
                    nxt_s.rdy_oe_n = 1'b1;
                    nxt_s.wr_pulse = wr_act;
                    nxt_s.rd_pulse = rd_act;
                    nxt_s.wdata = data_in;
                    nxt_s.st = lbhp_pkg::LBHP_DONE;
                end
            end
            lbhp_pkg::LBHP_DONE: begin
                nxt_s.rdy_oe_n = 1'b1;
                if (rd_l && wr_l)
                    nxt_s.st = lbhp_pkg::LBHP_IDLE;
            end
            default: nxt_s.st = lbhp_pkg::LBHP_IDLE;
        endcase

        nxt_s.d_oe_n = !rd_act;
        nxt_s.dout = reg_rdata;

        for (int i = 0; i < 4; i++) begin
            nxt_s.irq_oe_n[i] = (interrupt_line_select != 2'(i));
            nxt_s.irq_o[i] = irq_pending && (interrupt_line_select == 2'(i));
        end

        // a stuck reset releases the ready, data bus and rom select pins; the selected interrupt line stays driven low
        if (s_ff.rst_int) begin
            nxt_s.st = lbhp_pkg::LBHP_IDLE;
            nxt_s.rdy_oe_n = 1'b1;
            nxt_s.d_oe_n = 1'b1;
            nxt_s.wr_pulse = 1'b0;
            nxt_s.rd_pulse = 1'b0;
            nxt_s.irq_o = 4'h0;
            nxt_s.rom_oe_n = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_ff <= '0;
            s_ff.rd_s <= 3'h7;
            s_ff.wr_s <= 3'h7;
            s_ff.mr_s <= 3'h7;
            s_ff.aq_s <= 3'h7;
            s_ff.strap_s <= 3'h7;
            s_ff.local_mode <= 1'b1;
            s_ff.rom_cs_n <= 1'b1;
            s_ff.rom_oe_n <= 1'b1;
            s_ff.wide_n <= 1'b1;
            s_ff.rdy_oe_n <= 1'b1;
            s_ff.d_oe_n <= 1'b1;
            s_ff.lat.ube_n <= 1'b1;
            s_ff.irq_oe_n <= 4'hf;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign data_out = s_ff.dout;
    assign data_oe_n = s_ff.d_oe_n;
    assign cycle_extend_ready_oe_n = s_ff.rdy_oe_n;
    assign wide_cycle_indicator_low = s_ff.wide_n;
    assign boot_rom_select_strap_out = s_ff.rom_cs_n;
    assign boot_rom_select_strap_oe_n = s_ff.rom_oe_n;
    assign reg_wr = s_ff.wr_pulse;
    assign reg_rd = s_ff.rd_pulse;
    assign reg_idx = s_ff.reg_idx;
    assign reg_wdata = s_ff.wdata;
    assign reg_lanes = s_ff.lanes;
    assign chip_reset = s_ff.rst_int;
    assign local_bus_mode = s_ff.local_mode;
    assign interrupt_line = s_ff.irq_o;
    assign interrupt_line_oe_n = s_ff.irq_oe_n;
endmodule : lbhp_top
`default_nettype wire

// ### lbhp_top_asserts.sv
// pin-level assertions of the local bus host port
`timescale 1ns/1ns
`default_nettype none
module lbhp_top_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // inputs watched
    input wire logic io_read_strobe_low,
    input wire logic address_qualifier,
    input wire logic reset_pin,
    input wire logic extend_en,
    input wire logic irq_pending,
    input wire logic [1:0] interrupt_line_select,
    // outputs watched
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic data_oe_n,
    input wire logic cycle_extend_ready_oe_n,
    input wire logic chip_reset,
    input wire logic [3:0] interrupt_line,
    input wire logic [3:0] interrupt_line_oe_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_rd_strobe: assert property (reg_rd |-> !$past(io_read_strobe_low, 3))
        else $error("read pulse without strobe");
    chk_qual_low: assert property (reg_rd || reg_wr |-> !$past(address_qualifier, 4))
        else $error("access while qualifier high");
    chk_bus_read: assert property ($fell(data_oe_n) |-> !$past(io_read_strobe_low, 3))
        else $error("data bus driven outside read");
    // wait is exactly two cycles long
    chk_wait_two: assert property ($fell(cycle_extend_ready_oe_n) |->
        ##1 !cycle_extend_ready_oe_n ##1 cycle_extend_ready_oe_n) else $error("wait length");
    chk_wait_en: assert property (!cycle_extend_ready_oe_n |-> extend_en)
        else $error("wait without enable");
    chk_irq_route: assert property ($stable(interrupt_line_select) && $past(rst_n) &&
        !$past(chip_reset) |-> interrupt_line_oe_n == ~(4'h1 << interrupt_line_select))
        else $error("interrupt routing");
    chk_irq_level: assert property ($stable(irq_pending) && $past(rst_n) &&
        !$past(chip_reset) && $stable(interrupt_line_select) |->
        interrupt_line[interrupt_line_select] == irq_pending) else $error("interrupt level");
    chk_rst_filter: assert property ($rose(chip_reset) |-> $past(reset_pin, 1) &&
        $past(reset_pin, 8) && $past(reset_pin, 15)) else $error("reset glitch accepted");
endmodule : lbhp_top_chk
bind lbhp_top lbhp_top_chk lbhp_top_chk_i (.*);
`default_nettype wire

// ### lbhp_host.sv
// host processor model on the local bus
`timescale 1ns/1ns
`default_nettype none
module lbhp_host (
    // clock and lines read back
    input wire logic sys_clk,
    input wire logic ready,
    input wire logic rom_cs_n,
    input wire logic [15:0] bus,
    // host pins
    output logic [19:0] addr_in,
    output logic address_qualifier,
    output logic upper_byte_enable_low,
    output logic address_latch_strobe,
    output logic io_read_strobe_low,
    output logic io_write_strobe_low,
    output logic memory_read_strobe_low,
    output logic [15:0] wd,
    output logic wd_oe
);
    logic [15:0] rd_ff;
    logic cs_ff;
    initial begin
        {address_qualifier, upper_byte_enable_low, io_read_strobe_low} = 3'h7;
        {io_write_strobe_low, memory_read_strobe_low, address_latch_strobe, wd_oe} = 4'hc;
        {addr_in, wd} = 36'h0;
    end
    // kind 0 io read, 1 io write, 2 memory read
    task automatic access(input int kind, input logic [19:0] a, input logic u,
                          input logic q, input logic lat, input logic [15:0] d);
        @(posedge sys_clk);
        // whole address and lane enable set up first
        {addr_in, upper_byte_enable_low, address_qualifier} <= {a, u, q};
        {address_latch_strobe, wd, wd_oe} <= {lat, d, kind == 1};
        @(posedge sys_clk);
        address_latch_strobe <= 1'b0;
        repeat (5) @(posedge sys_clk);
        // latched values leave the pins so only the captured copy can be right
        if (lat) {addr_in, upper_byte_enable_low} <= ~{a, u};
        {memory_read_strobe_low, io_write_strobe_low, io_read_strobe_low} <= ~(3'h1 << kind);
        // hold the cycle until ready is released
        for (int n = 0; n < 24 && (n < 6 || !ready); n++) @(posedge sys_clk);
        repeat (3) @(posedge sys_clk);
        {rd_ff, cs_ff} = {bus, rom_cs_n};
        {memory_read_strobe_low, io_write_strobe_low, io_read_strobe_low} <= 3'h7;
        {addr_in, address_qualifier, wd_oe} <= {~addr_in, 2'b10};
        repeat (6) @(posedge sys_clk);
    endtask : access
endmodule : lbhp_host
`default_nettype wire

// ### tb_lbhp_top.sv
// self-checking bench of the local bus host port
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, w) begin checks_done++; if ((g) !== (w)) begin bad_count++; \
    $display("ERROR %0t got %h want %h", $time, g, w); end end
module tb_lbhp_top;
    logic sys_clk = 1'b0, rst_n = 1'b0, reset_pin = 1'b0, use_latch = 1'b0, strap = 1'b1;
    logic wide_mode = 1'b0, irq_pending = 1'b0, extend_en = 1'b0;
    logic [1:0] interrupt_line_select = 2'h0;
    logic [15:0] reg_rdata = 16'h0;
    logic [19:0] addr_in;
    logic [15:0] data_out, reg_wdata, wdat_ff, host_wd;
    logic [3:0] reg_idx, idx_ff, interrupt_line, interrupt_line_oe_n;
    logic [1:0] reg_lanes, lanes_ff;
    logic address_qualifier, upper_byte_enable_low, address_latch_strobe, io_read_strobe_low;
    logic io_write_strobe_low, memory_read_strobe_low, data_oe_n, cycle_extend_ready_oe_n;
    logic boot_rom_select_strap_out, boot_rom_select_strap_oe_n, reg_wr, reg_rd, chip_reset;
    logic local_bus_mode, host_wd_oe, wide_cycle_indicator_low, wide_ff;
    int bad_count = 0, checks_done = 0, seed = 21, wr_seen = 0, rd_seen = 0;
    // released bus floats to the weak pullups
    wire logic [15:0] dbus = !data_oe_n ? data_out : (host_wd_oe ? host_wd : 16'hffff);
    wire logic rom_pin = boot_rom_select_strap_oe_n ? strap : boot_rom_select_strap_out;
    always #4 sys_clk = ~sys_clk;
    lbhp_top lbhp_top_i (.*, .data_in(dbus), .io_base(16'h0300),
        .rom_base(20'hc0000), .rom_mask(20'hf0000), .boot_rom_select_strap_in(rom_pin));
    lbhp_host lbhp_host_i (.*, .ready(cycle_extend_ready_oe_n), .rom_cs_n(rom_pin), .bus(dbus),
        .wd(host_wd), .wd_oe(host_wd_oe));
    always @(posedge sys_clk) begin
        rd_seen += reg_rd;
        wr_seen += reg_wr;
        if (reg_wr) {idx_ff, wdat_ff, lanes_ff} = {reg_idx, reg_wdata, reg_lanes};
        // wide indicator is still decoded from the held address when the pulse leaves
        if (reg_wr || reg_rd) wide_ff = wide_cycle_indicator_low;
    end
    function automatic logic [1:0] exp_lanes(input logic u, input logic [19:0] a);
        return {~u, ~a[0]};
    endfunction : exp_lanes
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test
    task automatic run_io(input int kind, input logic [19:0] a, input logic q);
        logic u;
        logic [15:0] d;
        int w0;
        int r0;
        @(posedge sys_clk);
        {u, d, w0, r0} = {1'($random(seed)), 16'($random(seed)), wr_seen, rd_seen};
        lbhp_host_i.access(kind, a, u, q, use_latch, d);
        if (kind == 2) begin
            `CHK({lbhp_host_i.cs_ff, rd_seen}, {1'b0, r0})
        end else if (q || a[19]) begin
            `CHK(wr_seen + rd_seen, w0 + r0)
        end else if (kind == 1) begin
            `CHK({wr_seen, idx_ff, wdat_ff}, {w0 + 1, a[3:0], d})
            `CHK(lanes_ff, exp_lanes(u, a))
            `CHK(wide_ff, !wide_mode)
        end else begin
            `CHK({rd_seen, lbhp_host_i.rd_ff}, {r0 + 1, reg_rdata})
            `CHK(wide_ff, !wide_mode)
        end
    endtask : run_io
    task automatic pulse_reset(input int n, input logic s);
        strap <= s;
        reset_pin <= 1'b1;
        repeat (n) @(posedge sys_clk);
        `CHK(chip_reset, n > 20)
        reset_pin <= 1'b0;
        repeat (10) @(posedge sys_clk);
        `CHK({chip_reset, local_bus_mode}, {1'b0, n > 20 ? s : 1'b1})
    endtask : pulse_reset
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        `CHK(local_bus_mode, 1'b1)
        for (int i = 0; i < 16; i++) begin
            {use_latch, extend_en, wide_mode} <= {i[3], i[0], i[1]};
            reg_rdata <= $random(seed);
            run_io($random(seed) & 1, {8'h00, 8'h30, i < 2 ? {4{i[0]}} : 4'($random(seed))}, 0);
        end
        $display("random access test done");
        use_latch <= 1'b0;
        run_io(1, 20'h00305, 1'b1);
        run_io(0, 20'h80305, 1'b0);
        run_io(2, 20'hc0000, 1'b0);
        $display("refusal and rom test done");
        for (int i = 0; i < 8; i++) begin
            {irq_pending, interrupt_line_select} <= i[2:0];
            repeat (3) @(posedge sys_clk);
            `CHK(interrupt_line_oe_n, ~(4'h1 << i[1:0]))
            `CHK(interrupt_line[i[1:0]], i[2])
        end
        $display("interrupt test done");
        pulse_reset(5, 1'b1);
        pulse_reset(30, 1'b0);
        pulse_reset(30, 1'b1);
        $display("reset filter test done");
        end_of_test();
    end
    initial begin
        #100000;
        bad_count++;
        $display("ERROR %0t watchdog expired", $time);
        end_of_test();
    end
endmodule : tb_lbhp_top
`default_nettype wire
